// ### pkg/pfc_pkg.sv
// shared constants, register map and state type of the fault supervisor
package pfc_pkg;
	// clock and counter sizing
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
	localparam int unsigned CNT_W        = 24;

	// supervisory times in microseconds
	localparam int unsigned HL_FILTER_US = 300;
	localparam int unsigned LL_TIMER_US  = 25_000;
	localparam int unsigned LOCKOUT_US   = 500_000;
	localparam int unsigned BUV_DELAY_US = 515_000;
	localparam int unsigned SAG_BLANK_US = 20_000;
	localparam int unsigned BO_BLANK_US  = 50_000;
	localparam int unsigned REMOVAL_US   = 32_000;
	localparam int unsigned SAMPLE_US    = 1_000;

	// the same times in clock cycles
	localparam int unsigned HL_FILTER_CYC = HL_FILTER_US * CYC_PER_US;
	localparam int unsigned LL_TIMER_CYC  = LL_TIMER_US * CYC_PER_US;
	localparam int unsigned LOCKOUT_CYC   = LOCKOUT_US * CYC_PER_US;
	localparam int unsigned BUV_DELAY_CYC = BUV_DELAY_US * CYC_PER_US;
	localparam int unsigned SAG_BLANK_CYC = SAG_BLANK_US * CYC_PER_US;
	localparam int unsigned BO_BLANK_CYC  = BO_BLANK_US * CYC_PER_US;
	localparam int unsigned REMOVAL_CYC   = REMOVAL_US * CYC_PER_US;
	localparam int unsigned SAMPLE_CYC    = SAMPLE_US * CYC_PER_US;

	// synchronised pin vector layout
	localparam int unsigned PIN_BELOW_STOP  = 0;
	localparam int unsigned PIN_ABOVE_START = 1;
	localparam int unsigned PIN_ABOVE_HL    = 2;
	localparam int unsigned PIN_BELOW_LL    = 3;
	localparam int unsigned PIN_BELOW_DISCH = 4;
	localparam int unsigned PIN_SUPPLY_ON   = 5;
	localparam int unsigned PIN_TEMP_HOT    = 6;
	localparam int unsigned PIN_TEMP_COOL   = 7;
	localparam int unsigned PIN_FB_UVP      = 8;
	localparam int unsigned PIN_FB_BUV      = 9;
	localparam int unsigned PIN_FB_DRE      = 10;
	localparam int unsigned PIN_REDUND_OV   = 11;
	localparam int unsigned PIN_STATIC_OV   = 12;
	localparam int unsigned PIN_FB_NOMINAL  = 13;
	localparam int unsigned PIN_LEVEL_LSB   = 14;
	localparam int unsigned LEVEL_W         = 8;
	localparam int unsigned PIN_W           = PIN_LEVEL_LSB + LEVEL_W;

	// register map, byte addresses
	localparam logic [3:0]  CTRL_OFS     = 4'h0;
	localparam logic [3:0]  STATUS_OFS   = 4'h4;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam logic [31:0] CTRL_RESET   = 32'h00000001;
	localparam int unsigned STATE_LSB    = 10;

	typedef enum logic [2:0] {
		ST_OFF, ST_RUN, ST_STOP_BUV, ST_STOP_BO, ST_BUV_HOLD, ST_LATCHED, ST_DISCHARGE
	} state_t;
endpackage

// ### rtl/event_timer.sv
// run-gated counter that flags a terminal count of clock cycles
`timescale 1ns/1ns
`default_nettype none
module event_timer #(
	parameter int unsigned TERMINAL = 2
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// counting control and expiry
	input  wire logic run_i,
	output logic      done_o
);
	localparam logic [pfc_pkg::CNT_W-1:0] LAST = pfc_pkg::CNT_W'(TERMINAL - 1);
	logic [pfc_pkg::CNT_W-1:0] count_ff;

	// counts while run is high, restarts from zero when run drops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff <= '0;
			done_o   <= 1'b0;
		end else if (!run_i) begin
			count_ff <= '0;
			done_o   <= 1'b0;
		end else if (count_ff >= LAST) begin
			done_o   <= 1'b1; // holds while run stays high
		end else begin
			count_ff <= count_ff + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### rtl/pfc_fault_supervisor.sv
// supervisory fault sequencer with line-range, sag, brown-out and line-removal logic
// Operation
// [R1] Line below stop threshold for sag blanking time flags a line sag.
// [R2] Line sag starts a soft-stop and inhibits continuous conduction throughout.
// [R3] Line-recovered pulse resets the bulk-undervoltage restart delay.
// [R4] Line-recovered pulse aborts the soft-stop and grounds the control voltage.
// [R5] Operation starts only with line above start threshold and supply on.
// [R6] Line below stop threshold for brown-out blanking time is a brown-out fault.
// [R7] High-line selected after line above 236 V for 300 us.
// [R8] Low-line selected after line below 222 V for 25 ms.
// [R9] After going low-line, high-line is blocked for 500 ms.
// [R10] High-line divides bandwidth and gain by 4, halves foldback level.
// [R11] Line-removal detection runs in every state.
// [R12] Line samples restart removal timer on any slope; expiry means removal.
// [R13] Removal enables discharge sink, stops gate drive, grounds ready.
// [R14] Discharge sink stays on until line pin below discharge end threshold.
// [R15] Line back during discharge: keep discharging, then restart from start-up.
// [R16] Over-temperature turns off; stays off until temperature falls to cool.
// [R17] Feedback below 12 percent of reference is an output undervoltage fault.
// [R18] Redundant overvoltage with feedback not above 95.5 percent latches off.
// [R19] Hard faults stop drive, ground ready, enter lowest consumption at once.
// [R20] Bulk undervoltage grounds ready, soft-stops to static overvoltage, then off.
// [R21] Brown-out keeps ready high through soft-stop to static level, then off.
// [R22] Fault cleared: restart if supply on, else charge supply and wait.
// [R23] Feedback below 1.8 V reference flags bulk undervoltage.
// [R24] After bulk undervoltage soft-stop, wait 515 ms unless line recovers.
// [R25] All timers are clocked counters with parameter terminal counts.
`timescale 1ns/1ns
`default_nettype none
module pfc_fault_supervisor #(
	parameter int unsigned HL_FILTER_CYC = pfc_pkg::HL_FILTER_CYC,
	parameter int unsigned LL_TIMER_CYC  = pfc_pkg::LL_TIMER_CYC,
	parameter int unsigned LOCKOUT_CYC   = pfc_pkg::LOCKOUT_CYC,
	parameter int unsigned BUV_DELAY_CYC = pfc_pkg::BUV_DELAY_CYC,
	parameter int unsigned SAG_BLANK_CYC = pfc_pkg::SAG_BLANK_CYC,
	parameter int unsigned BO_BLANK_CYC  = pfc_pkg::BO_BLANK_CYC,
	parameter int unsigned REMOVAL_CYC   = pfc_pkg::REMOVAL_CYC,
	parameter int unsigned SAMPLE_CYC    = pfc_pkg::SAMPLE_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// line comparators
	input  wire logic        line_below_stop_i,
	input  wire logic        line_above_start_i,
	input  wire logic        line_above_hl_i,
	input  wire logic        line_below_ll_i,
	input  wire logic        line_below_discharge_i,
	input  wire logic [7:0]  line_level_i,
	// supply, feedback and temperature comparators
	input  wire logic        supply_on_i,
	input  wire logic        temp_hot_i,
	input  wire logic        temp_cool_i,
	input  wire logic        fb_below_uvp_i,
	input  wire logic        fb_below_buv_i,
	input  wire logic        fb_above_dre_i,
	input  wire logic        fb_near_nominal_i,
	input  wire logic        redundant_overvoltage_i,
	input  wire logic        static_overvoltage_level_i,
	// power stage controls
	output logic             gate_drive_en_o,
	output logic             converter_ready_out_o,
	output logic             soft_stop_o,
	output logic             vcontrol_ground_o,
	output logic             ccm_inhibit_o,
	output logic             discharge_sink_en_o,
	output logic             low_power_o,
	output logic             startup_charge_o,
	// line range controls
	output logic             high_line_o,
	output logic             bw_div4_o,
	output logic             foldback_half_o,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o
);
	logic [pfc_pkg::PIN_W-1:0] pin_s;
	logic below_stop, above_start, above_hl, below_ll, below_disch, supply_on;
	logic temp_hot, temp_cool, fb_uvp, fb_buv, fb_dre, redund_ov, static_ov, fb_nominal;
	logic [pfc_pkg::LEVEL_W-1:0] level_s;
	logic [pfc_pkg::LEVEL_W-1:0] prev_level_ff;
	pfc_pkg::state_t state_ff, nxt_state;
	logic sag_ff, recover_ff, bo_fault_ff, otp_ff, latched_shutdown_ff;
	logic high_line_ff, lockout_ff, armed_ff, slope_ff;
	logic sag_done, bo_done, hl_done, ll_done, lock_done, buv_done, rem_done, tick;
	logic low_line_fault, output_undervoltage_fault, supply_lockout_fault;
	logic over_temp_fault, bulk_undervoltage_fault, hard_fault, line_removal;
	logic [31:0] ctrl_ff;
	logic run_en;

	// every comparator and the line code pass two flip-flops
	pin_sync #(
		.WIDTH(pfc_pkg::PIN_W)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i({line_level_i, fb_near_nominal_i, static_overvoltage_level_i,
		          redundant_overvoltage_i, fb_above_dre_i, fb_below_buv_i, fb_below_uvp_i,
		          temp_cool_i, temp_hot_i, supply_on_i, line_below_discharge_i,
		          line_below_ll_i, line_above_hl_i, line_above_start_i, line_below_stop_i}),
		.sync_o (pin_s)
	);

	// named views of the synchronised pins
	assign below_stop  = pin_s[pfc_pkg::PIN_BELOW_STOP];
	assign above_start = pin_s[pfc_pkg::PIN_ABOVE_START];
	assign above_hl    = pin_s[pfc_pkg::PIN_ABOVE_HL];
	assign below_ll    = pin_s[pfc_pkg::PIN_BELOW_LL];
	assign below_disch = pin_s[pfc_pkg::PIN_BELOW_DISCH];
	assign supply_on   = pin_s[pfc_pkg::PIN_SUPPLY_ON];
	assign temp_hot    = pin_s[pfc_pkg::PIN_TEMP_HOT];
	assign temp_cool   = pin_s[pfc_pkg::PIN_TEMP_COOL];
	assign fb_uvp      = pin_s[pfc_pkg::PIN_FB_UVP];
	assign fb_buv      = pin_s[pfc_pkg::PIN_FB_BUV];
	assign fb_dre      = pin_s[pfc_pkg::PIN_FB_DRE];
	assign redund_ov   = pin_s[pfc_pkg::PIN_REDUND_OV];
	assign static_ov   = pin_s[pfc_pkg::PIN_STATIC_OV];
	assign fb_nominal  = pin_s[pfc_pkg::PIN_FB_NOMINAL];
	assign level_s     = pin_s[pfc_pkg::PIN_LEVEL_LSB +: pfc_pkg::LEVEL_W];

	// supervisory timers, all counting internal clock cycles
	event_timer #(.TERMINAL(SAG_BLANK_CYC)) u_sag ( // [R25]
		.clk_i(clk_i), .rst_i(rst_i), .run_i(below_stop), .done_o(sag_done)); // [R1]
	event_timer #(.TERMINAL(BO_BLANK_CYC)) u_bo (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(below_stop), .done_o(bo_done)); // [R6]
	event_timer #(.TERMINAL(HL_FILTER_CYC)) u_hl (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(above_hl && !high_line_ff && !lockout_ff),
		.done_o(hl_done)); // [R7] [R9]
	event_timer #(.TERMINAL(LL_TIMER_CYC)) u_ll (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(below_ll && high_line_ff),
		.done_o(ll_done)); // [R8]
	event_timer #(.TERMINAL(LOCKOUT_CYC)) u_lock (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(lockout_ff), .done_o(lock_done)); // [R9]
	event_timer #(.TERMINAL(BUV_DELAY_CYC)) u_buv (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(state_ff == pfc_pkg::ST_BUV_HOLD && !recover_ff),
		.done_o(buv_done)); // [R3] [R24]
	event_timer #(.TERMINAL(SAMPLE_CYC)) u_tick (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(!tick), .done_o(tick));
	event_timer #(.TERMINAL(REMOVAL_CYC)) u_rem (
		.clk_i(clk_i), .rst_i(rst_i), .run_i(!slope_ff), .done_o(rem_done)); // [R12]

	// sag flag and the one-cycle line-recovered pulse
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sag_ff     <= 1'b0;
			recover_ff <= 1'b0;
		end else begin
			sag_ff     <= below_stop && (sag_done || sag_ff); // [R1] stale done must not hold it
			recover_ff <= sag_ff && !below_stop; // [R3] [R4]
		end
	end

	// brown-out fault, cleared once the line is above the start threshold
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bo_fault_ff <= 1'b0;
		end else begin
			bo_fault_ff <= bo_done || (bo_fault_ff && !above_start); // [R6]
		end
	end

	// over-temperature with hysteresis and the permanent latch-off
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			otp_ff              <= 1'b0;
			latched_shutdown_ff <= 1'b0;
		end else begin
			otp_ff              <= temp_hot || (otp_ff && !temp_cool); // [R16]
			latched_shutdown_ff <= latched_shutdown_ff || (redund_ov && !fb_dre); // [R18]
		end
	end

	// line range selection with low-line lockout
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			high_line_ff <= 1'b0;
			lockout_ff   <= 1'b0;
		end else begin
			if (ll_done) begin
				high_line_ff <= 1'b0; // [R8]
			end else if (hl_done) begin
				high_line_ff <= 1'b1; // [R7]
			end
			if (ll_done) begin
				lockout_ff <= 1'b1; // [R9]
			end else if (lock_done) begin
				lockout_ff <= 1'b0;
			end
		end
	end

	// line sampling, slope detection and removal re-arm, active in every state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_level_ff <= '0;
			slope_ff      <= 1'b0;
			armed_ff      <= 1'b1;
		end else begin
			slope_ff <= tick && (level_s != prev_level_ff); // [R11] [R12]
			if (tick) begin
				prev_level_ff <= level_s;
			end
			if (slope_ff) begin
				armed_ff <= 1'b1;
			end else if (nxt_state == pfc_pkg::ST_DISCHARGE) begin
				armed_ff <= 1'b0; // removal consumed until the line moves again
			end
		end
	end

	// fault classification
	assign low_line_fault            = bo_fault_ff;
	assign over_temp_fault           = otp_ff;
	assign output_undervoltage_fault = fb_uvp; // [R17]
	assign supply_lockout_fault      = !supply_on;
	assign bulk_undervoltage_fault   = fb_buv; // [R23]
	assign hard_fault   = over_temp_fault || output_undervoltage_fault ||
	                      supply_lockout_fault || latched_shutdown_ff;
	assign line_removal = rem_done && armed_ff; // [R12]
	assign run_en       = ctrl_ff[pfc_pkg::CTRL_RUN_BIT];

	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pfc_pkg::ST_OFF: begin
				if (latched_shutdown_ff) begin
					nxt_state = pfc_pkg::ST_LATCHED;
				end else if (!hard_fault && !low_line_fault && above_start && run_en) begin
					nxt_state = pfc_pkg::ST_RUN; // [R5] [R22]
				end
			end
			pfc_pkg::ST_RUN: begin
				if (hard_fault) begin
					nxt_state = pfc_pkg::ST_OFF; // [R19]
				end else if (low_line_fault) begin
					nxt_state = pfc_pkg::ST_STOP_BO; // [R21]
				end else if (bulk_undervoltage_fault) begin
					nxt_state = pfc_pkg::ST_STOP_BUV; // [R20]
				end
			end
			pfc_pkg::ST_STOP_BUV: begin
				if (hard_fault || recover_ff) begin
					nxt_state = pfc_pkg::ST_OFF; // [R4] [R19]
				end else if (static_ov) begin
					nxt_state = pfc_pkg::ST_BUV_HOLD; // [R20]
				end
			end
			pfc_pkg::ST_STOP_BO: begin
				if (hard_fault || static_ov) begin
					nxt_state = pfc_pkg::ST_OFF; // [R21]
				end
			end
			pfc_pkg::ST_BUV_HOLD: begin
				if (recover_ff || buv_done) begin
					nxt_state = pfc_pkg::ST_OFF; // [R3] [R24]
				end
			end
			pfc_pkg::ST_LATCHED: begin
				nxt_state = pfc_pkg::ST_LATCHED; // [R18]
			end
			pfc_pkg::ST_DISCHARGE: begin
				if (below_disch) begin
					nxt_state = pfc_pkg::ST_OFF; // [R14] [R15]
				end
			end
			default: begin
				nxt_state = pfc_pkg::ST_OFF;
			end
		endcase
		if (line_removal && state_ff != pfc_pkg::ST_DISCHARGE) begin
			nxt_state = pfc_pkg::ST_DISCHARGE; // [R11] [R13]
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= pfc_pkg::ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// power stage outputs, registered from the next state except ccm_inhibit_o, which follows sag_ff
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gate_drive_en_o       <= 1'b0;
			converter_ready_out_o <= 1'b0;
			soft_stop_o           <= 1'b0;
			vcontrol_ground_o     <= 1'b1;
			ccm_inhibit_o         <= 1'b0;
			discharge_sink_en_o   <= 1'b0;
			low_power_o           <= 1'b1;
			startup_charge_o      <= 1'b0;
		end else begin
			gate_drive_en_o     <= nxt_state == pfc_pkg::ST_RUN ||
			                       nxt_state == pfc_pkg::ST_STOP_BUV ||
			                       nxt_state == pfc_pkg::ST_STOP_BO; // [R13] [R19]
			if (nxt_state == pfc_pkg::ST_RUN) begin
				converter_ready_out_o <= fb_nominal;
			end else if (nxt_state != pfc_pkg::ST_STOP_BO) begin
				converter_ready_out_o <= 1'b0; // [R13] [R19] [R20]
			end // brown-out soft-stop keeps ready as it was [R21]
			soft_stop_o         <= !recover_ff && (nxt_state == pfc_pkg::ST_STOP_BUV ||
			                       nxt_state == pfc_pkg::ST_STOP_BO ||
			                       (nxt_state == pfc_pkg::ST_RUN && sag_ff)); // [R2] [R4]
			vcontrol_ground_o   <= recover_ff || nxt_state != pfc_pkg::ST_RUN &&
			                       nxt_state != pfc_pkg::ST_STOP_BUV &&
			                       nxt_state != pfc_pkg::ST_STOP_BO; // [R4]
			ccm_inhibit_o       <= sag_ff; // [R2]
			discharge_sink_en_o <= nxt_state == pfc_pkg::ST_DISCHARGE; // [R13] [R14]
			low_power_o         <= nxt_state == pfc_pkg::ST_OFF ||
			                       nxt_state == pfc_pkg::ST_LATCHED ||
			                       nxt_state == pfc_pkg::ST_BUV_HOLD; // [R19]
			startup_charge_o    <= !supply_on && (nxt_state == pfc_pkg::ST_OFF ||
			                       nxt_state == pfc_pkg::ST_BUV_HOLD ||
			                       nxt_state == pfc_pkg::ST_LATCHED); // [R22]
		end
	end

	// line range driven gain and foldback settings
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			high_line_o     <= 1'b0;
			bw_div4_o       <= 1'b0;
			foldback_half_o <= 1'b0;
		end else begin
			high_line_o     <= high_line_ff;
			bw_div4_o       <= high_line_ff; // [R10]
			foldback_half_o <= high_line_ff; // [R10]
		end
	end

	// bus handshake: one wait cycle, then the request completes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		end
	end

	// control register write at the completing edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_ff <= pfc_pkg::CTRL_RESET;
		end else if (avs_write_i && !avs_waitrequest_o &&
		             avs_address_i[3:2] == pfc_pkg::CTRL_OFS[3:2]) begin
			ctrl_ff <= {31'h00000000, avs_writedata_i[pfc_pkg::CTRL_RUN_BIT]};
		end
	end

	// read data captured during the wait cycle, unmapped reads return zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i && avs_waitrequest_o) begin
			case (avs_address_i[3:2])
				pfc_pkg::CTRL_OFS[3:2]: begin
					avs_readdata_o <= ctrl_ff;
				end
				pfc_pkg::STATUS_OFS[3:2]: begin
					avs_readdata_o <= {19'h00000, state_ff, converter_ready_out_o,
					                   discharge_sink_en_o, latched_shutdown_ff,
					                   supply_lockout_fault, output_undervoltage_fault,
					                   over_temp_fault, bulk_undervoltage_fault,
					                   low_line_fault, sag_ff, high_line_ff};
				end
				default: begin
					avs_readdata_o <= 32'h00000000;
				end
			endcase
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sag_ccm_a: assert property (sag_ff |=> ccm_inhibit_o) // [R2]
		else $error("ccm not inhibited during sag");
	recover_ground_a: assert property (recover_ff |=> vcontrol_ground_o && !soft_stop_o) // [R4]
		else $error("recovery did not ground control voltage");
	buv_bypass_a: assert property ((state_ff == pfc_pkg::ST_BUV_HOLD && recover_ff) // [R3]
		|=> state_ff == pfc_pkg::ST_OFF) else $error("recovery did not end restart delay");
	start_cond_a: assert property ((state_ff == pfc_pkg::ST_OFF ##1 // [R5]
		state_ff == pfc_pkg::ST_RUN) |-> $past(above_start, 1) && $past(supply_on, 1))
		else $error("started without line and supply");
	bo_cause_a: assert property ($rose(bo_fault_ff) |-> $past(below_stop, 2)) // [R6]
		else $error("brown-out without low line");
	lowline_lock_a: assert property ($fell(high_line_ff) |-> !high_line_ff [*8]) // [R9]
		else $error("high line reselected during lockout");
	removal_out_a: assert property ((line_removal && state_ff != pfc_pkg::ST_DISCHARGE) // [R13]
		|=> discharge_sink_en_o && !gate_drive_en_o && !converter_ready_out_o)
		else $error("removal did not start discharge");
	disch_hold_a: assert property ((state_ff == pfc_pkg::ST_DISCHARGE && !below_disch) // [R14]
		|=> state_ff == pfc_pkg::ST_DISCHARGE) else $error("discharge ended early");
	hard_off_a: assert property ((hard_fault && state_ff == pfc_pkg::ST_RUN && !line_removal) // [R19]
		|=> !gate_drive_en_o && !converter_ready_out_o && low_power_o)
		else $error("hard fault did not stop at once");
	latch_hold_a: assert property (latched_shutdown_ff |=> latched_shutdown_ff) // [R18]
		else $error("latched shutdown released");
	otp_hold_a: assert property ((otp_ff && !temp_cool) |=> otp_ff) // [R16]
		else $error("over-temperature released while hot");
endmodule
`default_nettype wire

// ### rtl/pin_sync.sv
// two flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// pins and their synchronised copy
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;

	// first stage feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_ff[g] <= 1'b0;
					sync_o[g]  <= 1'b0;
				end else begin
					meta_ff[g] <= async_i[g];
					sync_o[g]  <= meta_ff[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### testbench/downstream_model.sv
// downstream converter model that runs while the ready output is high
`timescale 1ns/1ns
`default_nettype none
module downstream_model (
	// clock and enable
	input  wire logic clk_i,
	input  wire logic ready_i,
	// converter activity
	output logic      running_o
);
	// follows the enable level one cycle later
	always_ff @(posedge clk_i) running_o <= ready_i;
endmodule
`default_nettype wire

// ### testbench/tb_pfc_fault_supervisor.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_pfc_fault_supervisor;
	logic clk_i = 0, rst_i = 1, mains = 0, running;
	logic line_below_stop_i = 0, line_above_start_i = 0, line_above_hl_i = 0;
	logic line_below_ll_i = 1, line_below_discharge_i = 0, supply_on_i = 0;
	logic temp_hot_i = 0, temp_cool_i = 1, fb_below_uvp_i = 0, fb_below_buv_i = 0;
	logic fb_above_dre_i = 1, fb_near_nominal_i = 1, redundant_overvoltage_i = 0;
	logic static_overvoltage_level_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic [7:0]  line_level_i = 8'h00;
	logic [3:0]  avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h00000000, avs_readdata_o, rd;
	logic gate_drive_en_o, converter_ready_out_o, soft_stop_o, vcontrol_ground_o;
	logic ccm_inhibit_o, discharge_sink_en_o, low_power_o, startup_charge_o;
	logic high_line_o, bw_div4_o, foldback_half_o, avs_waitrequest_o;
	int   err_count = 0, n_tests = 0;
	wire  logic [4:0] mon = {discharge_sink_en_o, ccm_inhibit_o, high_line_o,
		converter_ready_out_o, gate_drive_en_o};
	// 20 MHz clock
	always #25 clk_i = ~clk_i;
	// line code ramps while mains is present, so slopes keep showing
	always @(posedge clk_i) if (mains) line_level_i <= line_level_i + 8'h01;
	pfc_fault_supervisor #(.HL_FILTER_CYC(8), .LL_TIMER_CYC(16), .LOCKOUT_CYC(32),
		.BUV_DELAY_CYC(40), .SAG_BLANK_CYC(16), .BO_BLANK_CYC(32), .REMOVAL_CYC(48),
		.SAMPLE_CYC(4)) pfc_fault_supervisor_inst (.clk_i, .rst_i, .line_below_stop_i,
		.line_above_start_i, .line_above_hl_i, .line_below_ll_i, .line_below_discharge_i,
		.line_level_i, .supply_on_i, .temp_hot_i, .temp_cool_i, .fb_below_uvp_i,
		.fb_below_buv_i, .fb_above_dre_i, .fb_near_nominal_i, .redundant_overvoltage_i,
		.static_overvoltage_level_i, .gate_drive_en_o, .converter_ready_out_o,
		.soft_stop_o, .vcontrol_ground_o, .ccm_inhibit_o, .discharge_sink_en_o,
		.low_power_o, .startup_charge_o, .high_line_o, .bw_div4_o, .foldback_half_o,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o);
	downstream_model downstream_model_inst (.clk_i, .ready_i(converter_ready_out_o),
		.running_o(running));
	// verdict and end of run
	task close_out;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one avalon transfer, held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (i == 20) begin
			err_count++;
			close_out();
		end
	endtask
	// bounded wait for one monitored output to reach a level
	task wait_on(input int b, input logic v);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(posedge clk_i);
			if (mon[b] === v) break;
		end
		if (i == 3000) begin
			err_count++;
			close_out();
		end
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK(low_power_o, 1'b1);
		bus(0, 4'h0, 32'h0);
		`CHK(rd, 32'h00000001);
		bus(0, 4'hC, 32'h0);
		`CHK(rd, 32'h00000000);
		bus(1, 4'h0, 32'h0);
		mains <= 1'b1;
		supply_on_i <= 1'b1;
		line_above_start_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		`CHK(gate_drive_en_o, 1'b0);
		bus(1, 4'h0, 32'h1);
		wait_on(0, 1'b1);
		`CHK(converter_ready_out_o, 1'b1);
		@(posedge clk_i);
		`CHK(running, 1'b1);
		$display("start done");
		line_below_ll_i <= 1'b0;
		line_above_hl_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		`CHK(high_line_o, 1'b0);
		wait_on(2, 1'b1);
		`CHK({bw_div4_o, foldback_half_o}, 2'h3);
		line_above_hl_i <= 1'b0;
		line_below_ll_i <= 1'b1;
		wait_on(2, 1'b0);
		line_above_hl_i <= 1'b1;
		line_below_ll_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		`CHK(high_line_o, 1'b0);
		wait_on(2, 1'b1);
		$display("line range done");
		temp_hot_i <= 1'b1;
		temp_cool_i <= 1'b0;
		wait_on(0, 1'b0);
		`CHK({converter_ready_out_o, low_power_o}, 2'h1);
		temp_hot_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		`CHK(gate_drive_en_o, 1'b0);
		temp_cool_i <= 1'b1;
		wait_on(0, 1'b1);
		$display("temperature done");
		mains <= 1'b0;
		wait_on(4, 1'b1);
		`CHK({gate_drive_en_o, converter_ready_out_o}, 2'h0);
		mains <= 1'b1;
		repeat (20) @(posedge clk_i);
		`CHK(discharge_sink_en_o, 1'b1);
		line_below_discharge_i <= 1'b1;
		wait_on(4, 1'b0);
		line_below_discharge_i <= 1'b0;
		wait_on(0, 1'b1);
		$display("line removal done");
		line_below_stop_i <= 1'b1;
		line_above_start_i <= 1'b0;
		wait_on(3, 1'b1);
		`CHK(soft_stop_o, 1'b1);
		repeat (20) @(posedge clk_i);
		bus(0, 4'h4, 32'h0);
		`CHK(rd[2], 1'b1);
		`CHK(converter_ready_out_o, 1'b1);
		static_overvoltage_level_i <= 1'b1;
		wait_on(0, 1'b0);
		`CHK({converter_ready_out_o, low_power_o}, 2'h1);
		$display("brown-out done");
		line_below_stop_i <= 1'b0;
		line_above_start_i <= 1'b1;
		static_overvoltage_level_i <= 1'b0;
		wait_on(0, 1'b1);
		fb_below_buv_i <= 1'b1;
		wait_on(1, 1'b0);
		`CHK({gate_drive_en_o, soft_stop_o, vcontrol_ground_o}, 3'h6);
		static_overvoltage_level_i <= 1'b1;
		wait_on(0, 1'b0);
		`CHK(low_power_o, 1'b1);
		fb_below_buv_i <= 1'b0;
		static_overvoltage_level_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		`CHK(gate_drive_en_o, 1'b0);
		wait_on(0, 1'b1);
		fb_below_buv_i <= 1'b1;
		static_overvoltage_level_i <= 1'b1;
		wait_on(0, 1'b0);
		fb_below_buv_i <= 1'b0;
		line_below_stop_i <= 1'b1;
		wait_on(3, 1'b1);
		line_below_stop_i <= 1'b0;
		static_overvoltage_level_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		`CHK(gate_drive_en_o, 1'b1);
		$display("bulk undervoltage done");
		fb_below_uvp_i <= 1'b1;
		wait_on(0, 1'b0);
		`CHK({converter_ready_out_o, low_power_o}, 2'h1);
		fb_below_uvp_i <= 1'b0;
		supply_on_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		`CHK(startup_charge_o, 1'b1);
		supply_on_i <= 1'b1;
		wait_on(0, 1'b1);
		fb_above_dre_i <= 1'b0;
		redundant_overvoltage_i <= 1'b1;
		wait_on(0, 1'b0);
		redundant_overvoltage_i <= 1'b0;
		fb_above_dre_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		bus(0, 4'h4, 32'h0);
		`CHK(rd[12:7], 6'h29);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_on(0, 1'b1);
		$display("hard faults done");
		close_out();
	end
endmodule
`default_nettype wire
